// ### dv/tpc_trig_partner.sv
// Equipment on the trigger connector: pulses the input pin, times the output pin.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module tpc_trig_partner (
   input wire logic i_clk,
   input wire logic i_pin_out,
   output logic o_pin_in
);
   initial o_pin_in = 1'b0;
   task automatic pulse(input int n);
      o_pin_in <= 1'b1;
      repeat (n) @(posedge i_clk);
      o_pin_in <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask : pulse
   task automatic measure(input int n, output int hi);
      hi = 0;
      repeat (n) begin
         @(negedge i_clk);
         hi += int'(i_pin_out === 1'b1);
      end
      @(posedge i_clk);
   endtask : measure
endmodule : tpc_trig_partner
`default_nettype wire

// ### dv/tpc_trigger_pin_ctrl_bench.sv
// Bench for the trigger pin controller: a table of input and output cases,
// then static level, test mode, reset and register cases.
// Assumes one millisecond shortened to P_MS_CYCLES clocks.
`include "tpc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tpc_trigger_pin_ctrl_bench;
   localparam int unsigned P_MS_CYCLES = 10;
   typedef struct {bit o; logic [2:0] sel; logic [5:0] wid; int stim; int exp;} tpc_row_t;
   logic i_clk, i_sys_rst, i_avs_read, i_avs_write, i_trig_in, o_trig_out, i_test_mode;
   logic o_avs_waitrequest, st;
   logic [4:0] i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, rd;
   logic [3:0] slot;
   logic [15:0] volt, freq;
   tpc_pkg::tpc_event_t i_evt;
   tpc_pkg::tpc_action_t o_act;
   int fail_count, total_checks, fires, rem, hi;
   // Input rows count fires as hex digits: surge, preset, setting, output
   tpc_row_t rows[20] = '{'{0, 0, 1, 30, 0}, '{0, 1, 1, 30, 'h1}, '{0, 2, 2, 40, 'h10},
      '{0, 3, 1, 30, 'h100}, '{0, 4, 1, 100, 'h1000}, '{0, 4, 3, 25, 0}, '{0, 4, 0, 45, 0},
      '{0, 4, 0, 60, 'h1000}, '{0, 4, 60, 615, 'h1000}, '{1, 0, 1, 4, 0}, '{1, 1, 1, 4, 10},
      '{1, 1, 1, 3, 10}, '{1, 1, 1, 2, 0}, '{1, 2, 1, 2, 10}, '{1, 2, 1, 0, 0},
      '{1, 3, 1, 1, 10}, '{1, 3, 1, 0, 10}, '{1, 3, 1, 4, 0}, '{1, 4, 1, 0, 10},
      '{1, 4, 2, 3, 20}};
   logic [4:0] ra[5] = '{`TPC_OFS_IN_CFG, `TPC_OFS_VSET, `TPC_OFS_FSET, `TPC_OFS_OUT_CFG, 5'h18};
   logic [31:0] rv[5] = '{`TPC_RST_IN_CFG, 32'h0, {16'h0, `TPC_RST_FSET}, `TPC_RST_OUT_CFG, 32'h0};
   tpc_trigger_pin_ctrl #(.P_MS_CYCLES(P_MS_CYCLES)) dut_u (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_trig_in(i_trig_in), .o_trig_out(o_trig_out),
      .i_test_mode(i_test_mode), .i_evt(i_evt), .o_act(o_act));
   tpc_trig_partner partner_u (.i_clk(i_clk), .i_pin_out(o_trig_out), .o_pin_in(i_trig_in));
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   always @(negedge i_clk) begin
      fires += int'(o_act.out_ctrl_pulse) + 16 * int'(o_act.setting_pulse)
         + 256 * int'(o_act.preset_pulse) + 4096 * int'(o_act.surge_start);
      rem += int'(o_act.remote_trig);
      if (o_act.out_ctrl_pulse === 1'b1) st = o_act.out_state;
      if (o_act.preset_pulse === 1'b1) slot = o_act.preset_slot;
      if (o_act.setting_pulse === 1'b1) volt = o_act.volt_value;
      if (o_act.setting_pulse === 1'b1) freq = o_act.freq_value;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= w;
      i_avs_read <= !w;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata;
      // Answer comes one cycle after the request is seen
      chk("bus answer cycles", 2, n);
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      @(posedge i_clk);
   endtask : bus
   task automatic evt(input int b);
      i_evt <= tpc_pkg::tpc_event_t'(5'h01 << b);
      @(posedge i_clk);
      i_evt <= '0;
   endtask : evt
   task automatic summarize;
      $display("Checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (30000) @(posedge i_clk);
      fail_count++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      summarize();
   end
   initial begin
      i_sys_rst = 1'b1;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_address = 5'h00;
      i_avs_writedata = 32'h0;
      i_test_mode = 1'b0;
      i_evt = '0;
      repeat (16) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      bus(1, `TPC_OFS_VSET, 32'h0000_1234);
      bus(1, `TPC_OFS_FSET, 32'h0000_1194);
      foreach (rows[k]) begin
         if (rows[k].o) begin
            bus(1, `TPC_OFS_OUT_CFG, {18'h0, rows[k].wid, 5'h0, rows[k].sel});
            evt(rows[k].stim);
            partner_u.measure(40, hi);
            chk("trig_out high cycles", rows[k].exp, hi);
         end else begin
            bus(1, `TPC_OFS_IN_CFG, {16'h0901, 2'h0, rows[k].wid, 5'h0, rows[k].sel});
            fires = 0;
            partner_u.pulse(rows[k].stim);
            repeat (16) @(posedge i_clk);
            chk("action pulses", rows[k].exp, fires);
         end
         $display("Case %0d done", k);
      end
      chk("out_state", 1, st);
      chk("preset_slot", 9, slot);
      chk("volt_value", 32'h1234, volt);
      chk("freq_value", 32'h1194, freq);
      bus(1, `TPC_OFS_OUT_CFG, 32'h0001_0001);
      repeat (3) @(posedge i_clk);
      chk("static idle high level", 0, o_trig_out);
      evt(4);
      // Pin follows the latch one edge later
      @(posedge i_clk);
      partner_u.measure(30, hi);
      chk("static latched high", 30, hi);
      bus(1, `TPC_OFS_OUT_CFG, 32'h0000_0001);
      repeat (3) @(posedge i_clk);
      chk("static idle low level", 1, o_trig_out);
      evt(3);
      @(posedge i_clk);
      partner_u.measure(30, hi);
      chk("static latched low", 0, hi);
      $display("Static level test done");
      i_test_mode <= 1'b1;
      bus(1, `TPC_OFS_OUT_CFG, 32'h0000_0104);
      evt(2);
      partner_u.measure(40, hi);
      chk("test mode trig_out", 0, hi);
      bus(1, `TPC_OFS_IN_CFG, 32'h0000_0104);
      fires = 0;
      partner_u.pulse(30);
      chk("test mode fire", 0, fires);
      rem = 0;
      bus(1, `TPC_OFS_CMD, 32'h1);
      repeat (4) @(posedge i_clk);
      chk("remote fire", 32'h1000, fires);
      chk("remote flag", 1, rem);
      // Idle pin, idle input, test mode flag alone
      bus(0, `TPC_OFS_STATUS, 32'h0);
      chk("status word", 32'h1, rd);
      i_test_mode <= 1'b0;
      bus(1, `TPC_OFS_OUT_CFG, 32'h0000_0100);
      bus(1, `TPC_OFS_CMD, 32'h2);
      partner_u.measure(40, hi);
      chk("remote trig_out", 10, hi);
      $display("Test mode test done");
      i_sys_rst <= 1'b1;
      repeat (4) @(posedge i_clk);
      chk("reset trig_out", 0, o_trig_out);
      chk("reset waitrequest", 1, o_avs_waitrequest);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      bus(1, 5'h18, 32'hffff_ffff);
      foreach (ra[k]) begin
         bus(0, ra[k], 32'h0);
         chk("register reset value", rv[k], rd);
      end
      $display("Reset test done");
      summarize();
   end
endmodule : tpc_trigger_pin_ctrl_bench
bind tpc_trigger_pin_ctrl tpc_trigger_pin_ctrl_chk #(.P_MS_CYCLES(P_MS_CYCLES)) chk_u (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_trig_in(i_trig_in), .o_trig_out(o_trig_out),
   .i_test_mode(i_test_mode), .i_evt(i_evt), .o_act(o_act));
`default_nettype wire

// ### dv/tpc_trigger_pin_ctrl_chk.sv
// Checker for the trigger pin controller, bound to its top module.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module tpc_trigger_pin_ctrl_chk #(
   parameter int unsigned P_MS_CYCLES = 10
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic i_trig_in,
   input wire logic o_trig_out,
   input wire logic i_test_mode,
   input wire tpc_pkg::tpc_event_t i_evt,
   input wire tpc_pkg::tpc_action_t o_act
);
   logic [3:0] cause_age;
   logic fire;
   assign fire = o_act.out_ctrl_pulse | o_act.setting_pulse | o_act.preset_pulse
      | o_act.surge_start;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // Reset counts as a cause, since static idle level appears on release
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cause_age <= 4'h0;
      end else if ((|i_evt) || i_avs_write) begin
         cause_age <= 4'h0;
      end else if (cause_age != 4'hf) begin
         cause_age <= cause_age + 4'h1;
      end
   end
   chk_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("bus request not answered next cycle");
   chk_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   chk_wait_idle: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> o_avs_waitrequest) else $error("answer without request");
   chk_rdata_stands: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> $stable(o_avs_readdata)) else $error("read data changed while idle");
   chk_fire_single: assert property (fire |=> !fire) else $error("action fired twice");
   chk_fire_width: assert property (fire && !o_act.remote_trig
      |-> $past(i_trig_in, 5) && $past(i_trig_in, P_MS_CYCLES + 2))
      else $error("action fired without a qualified pin pulse");
   chk_out_cause: assert property ($rose(o_trig_out) |-> cause_age <= 4'h4)
      else $error("trigger output rose without an event");
   chk_test_block: assert property (fire && !o_act.remote_trig
      |-> !($past(i_test_mode, 1) && $past(i_test_mode, 2)))
      else $error("pin action fired in test mode");
endmodule : tpc_trigger_pin_ctrl_chk
`default_nettype wire

// ### logic/tpc_consts.svh
// Constants for the trigger pin controller: register offsets, field
// positions, reset values and timing figures.
// Assumes a 250 MHz system clock and a 32-bit register bus.
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH

// Byte offsets of the registers
`define TPC_OFS_IN_CFG 5'h00
`define TPC_OFS_VSET 5'h04
`define TPC_OFS_FSET 5'h08
`define TPC_OFS_OUT_CFG 5'h0c
`define TPC_OFS_STATUS 5'h10
`define TPC_OFS_CMD 5'h14

// Input configuration fields
`define TPC_IN_ACT_LSB 0
`define TPC_IN_WID_LSB 8
`define TPC_IN_STAT_BIT 16
`define TPC_IN_SLOT_LSB 24
// Output configuration fields
`define TPC_OUT_SRC_LSB 0
`define TPC_OUT_WID_LSB 8
`define TPC_OUT_LVL_BIT 16
// Command bits
`define TPC_CMD_IN_BIT 0
`define TPC_CMD_OUT_BIT 1

// Reset values
`define TPC_RST_IN_CFG 32'h0000_0000
`define TPC_RST_VSET 16'h0000
`define TPC_RST_FSET 16'h1388
`define TPC_RST_OUT_CFG 32'h0000_0000

// Timing
`define TPC_CLK_PERIOD_NS 4
`define TPC_MS_NS 1000000
`define TPC_MS_CYCLES (`TPC_MS_NS / `TPC_CLK_PERIOD_NS)
`define TPC_IN_WID_ZERO_MS 6'h05
`define TPC_WID_MAX_MS 6'h3c

`endif

// ### logic/tpc_pkg.sv
// Types for the trigger pin controller.
// Assumes tpc_consts.svh carries all numeric constants except the enum codes below.
package tpc_pkg;

   typedef enum logic [2:0] {
      TPC_ACT_NONE = 3'h0,
      TPC_ACT_OUTPUT = 3'h1,
      TPC_ACT_SETTING = 3'h2,
      TPC_ACT_PRESET = 3'h3,
      TPC_ACT_SURGE = 3'h4
   } tpc_in_action_t;

   typedef enum logic [2:0] {
      TPC_SRC_NONE = 3'h0,
      TPC_SRC_OUTPUT = 3'h1,
      TPC_SRC_SETTING = 3'h2,
      TPC_SRC_PRESET = 3'h3,
      TPC_SRC_ALL = 3'h4
   } tpc_out_source_t;

   typedef enum logic [1:0] {
      TPC_IN_IDLE = 2'h0,
      TPC_IN_MEASURE = 2'h1,
      TPC_IN_WAIT_LOW = 2'h2
   } tpc_in_state_t;

   // Requests toward the instrument's engines
   typedef struct packed {
      logic out_ctrl_pulse;
      logic out_state;
      logic setting_pulse;
      logic [15:0] volt_value;
      logic [15:0] freq_value;
      logic preset_pulse;
      logic [3:0] preset_slot;
      logic surge_start;
      logic remote_trig;
   } tpc_action_t;

   // Events reported by the instrument
   typedef struct packed {
      logic output_on;
      logic output_off;
      logic setting_change;
      logic preset_save;
      logic preset_load;
   } tpc_event_t;

endpackage : tpc_pkg

// ### logic/tpc_trigger_pin_ctrl.sv
// Trigger pin controller: qualifies the trigger input pin, fires the
// selected action, and drives the trigger output pin from internal events.
// Assumes events and test mode come from logic on i_clk; the input pin is
// asynchronous. Registers are reached over Avalon-MM with waitrequest.
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`include "tpc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module tpc_trigger_pin_ctrl #(
   parameter int unsigned P_MS_CYCLES = `TPC_MS_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_trig_in,
   output logic o_trig_out,
   input wire logic i_test_mode,
   input wire tpc_pkg::tpc_event_t i_evt,
   output var tpc_pkg::tpc_action_t o_act
);

   logic [31:0] in_cfg_reg;
   logic [15:0] vset_reg;
   logic [15:0] fset_reg;
   logic [31:0] out_cfg_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic sync1_reg;
   logic sync2_reg;
   tpc_pkg::tpc_in_state_t in_state_reg;
   logic [31:0] in_cyc_reg;
   logic [5:0] in_ms_reg;
   logic out_busy_reg;
   logic [31:0] out_cyc_reg;
   logic [5:0] out_ms_reg;
   logic out_latch_reg;
   logic trig_out_reg;
   logic remote_in_reg;
   logic remote_out_reg;
   tpc_pkg::tpc_action_t act_reg;

   logic wr_en;
   logic rd_en;
   logic [31:0] be_mask;
   tpc_pkg::tpc_in_action_t in_action;
   tpc_pkg::tpc_out_source_t out_source;
   logic [5:0] in_width;
   logic [5:0] in_need_ms;
   logic [5:0] out_width;
   logic out_level;
   logic in_qualified;
   logic in_fire;
   logic out_event;

   assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                     {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   // A request is answered in the cycle after it is seen
   assign wr_en = i_avs_write && !wait_reg;
   assign rd_en = i_avs_read && !wait_reg;

   assign in_action = tpc_pkg::tpc_in_action_t'(in_cfg_reg[`TPC_IN_ACT_LSB +: 3]);
   assign in_width = in_cfg_reg[`TPC_IN_WID_LSB +: 6];
   assign out_source = tpc_pkg::tpc_out_source_t'(out_cfg_reg[`TPC_OUT_SRC_LSB +: 3]);
   assign out_width = out_cfg_reg[`TPC_OUT_WID_LSB +: 6];
   assign out_level = out_cfg_reg[`TPC_OUT_LVL_BIT];

   assign in_need_ms = (in_width == 6'h00) ? `TPC_IN_WID_ZERO_MS : in_width;

   // Bus handshake: waitrequest drops for exactly one cycle per request
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wait_reg <= 1'b1;
      end else if ((i_avs_read || i_avs_write) && wait_reg) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   // Configuration registers
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         in_cfg_reg <= `TPC_RST_IN_CFG;
         vset_reg <= `TPC_RST_VSET;
         fset_reg <= `TPC_RST_FSET;
         out_cfg_reg <= `TPC_RST_OUT_CFG;
      end else if (wr_en) begin
         if (i_avs_address == `TPC_OFS_IN_CFG) begin
            in_cfg_reg <= (in_cfg_reg & ~be_mask) | (i_avs_writedata & be_mask);
         end else if (i_avs_address == `TPC_OFS_VSET) begin
            vset_reg <= (vset_reg & ~be_mask[15:0]) | (i_avs_writedata[15:0] & be_mask[15:0]);
         end else if (i_avs_address == `TPC_OFS_FSET) begin
            fset_reg <= (fset_reg & ~be_mask[15:0]) | (i_avs_writedata[15:0] & be_mask[15:0]);
         end else if (i_avs_address == `TPC_OFS_OUT_CFG) begin
            out_cfg_reg <= (out_cfg_reg & ~be_mask) | (i_avs_writedata & be_mask);
         end
      end
   end

   // Remote trigger commands, one-cycle pulses
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         remote_in_reg <= 1'b0;
         remote_out_reg <= 1'b0;
      end else begin
         remote_in_reg <= wr_en && (i_avs_address == `TPC_OFS_CMD)
                          && i_avs_byteenable[0] && i_avs_writedata[`TPC_CMD_IN_BIT];
         remote_out_reg <= wr_en && (i_avs_address == `TPC_OFS_CMD)
                           && i_avs_byteenable[0] && i_avs_writedata[`TPC_CMD_OUT_BIT];
      end
   end

   // Read data; unmapped and write-only offsets read as zero
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if ((i_avs_read || i_avs_write) && wait_reg) begin
         if (i_avs_address == `TPC_OFS_IN_CFG) begin
            rdata_reg <= in_cfg_reg;
         end else if (i_avs_address == `TPC_OFS_VSET) begin
            rdata_reg <= {16'h0000, vset_reg};
         end else if (i_avs_address == `TPC_OFS_FSET) begin
            rdata_reg <= {16'h0000, fset_reg};
         end else if (i_avs_address == `TPC_OFS_OUT_CFG) begin
            rdata_reg <= out_cfg_reg;
         end else if (i_avs_address == `TPC_OFS_STATUS) begin
            rdata_reg <= {26'h0, out_busy_reg, out_latch_reg, trig_out_reg,
                          in_state_reg, i_test_mode};
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end
   end

   // Two-stage synchronizer on the input pin
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= i_trig_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Width counted from the cycle after the synchronized rise, so a pulse must last
   // at least one clock more than the full width to qualify and a shorter one never does.
   assign in_qualified = (in_state_reg == tpc_pkg::TPC_IN_MEASURE) && sync2_reg
                         && (in_cyc_reg == P_MS_CYCLES - 1)
                         && (in_ms_reg + 6'h01 >= in_need_ms);

   // Measurement state machine, one fire per pulse
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         in_state_reg <= tpc_pkg::TPC_IN_IDLE;
         in_cyc_reg <= 32'h0000_0000;
         in_ms_reg <= 6'h00;
      end else begin
         case (in_state_reg)
            tpc_pkg::TPC_IN_IDLE: begin
               in_cyc_reg <= 32'h0000_0000;
               in_ms_reg <= 6'h00;
               if (sync2_reg) begin
                  in_state_reg <= tpc_pkg::TPC_IN_MEASURE;
               end
            end
            tpc_pkg::TPC_IN_MEASURE: begin
               if (!sync2_reg) begin
                  in_state_reg <= tpc_pkg::TPC_IN_IDLE;
               end else if (in_qualified) begin
                  in_state_reg <= tpc_pkg::TPC_IN_WAIT_LOW;
               end else if (in_cyc_reg == P_MS_CYCLES - 1) begin
                  in_cyc_reg <= 32'h0000_0000;
                  in_ms_reg <= in_ms_reg + 6'h01;
               end else begin
                  in_cyc_reg <= in_cyc_reg + 32'h0000_0001;
               end
            end
            tpc_pkg::TPC_IN_WAIT_LOW: begin
               if (!sync2_reg) begin
                  in_state_reg <= tpc_pkg::TPC_IN_IDLE;
               end
            end
            default: begin
               in_state_reg <= tpc_pkg::TPC_IN_IDLE;
            end
         endcase
      end
   end

   // Pin-driven actions are blocked while a test mode runs
   assign in_fire = (in_qualified && !i_test_mode) || remote_in_reg;

   // Action requests; values are held, strobes last one cycle
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         act_reg <= '0;
      end else begin
         act_reg.out_ctrl_pulse <= 1'b0;
         act_reg.setting_pulse <= 1'b0;
         act_reg.preset_pulse <= 1'b0;
         act_reg.surge_start <= 1'b0;
         act_reg.out_state <= in_cfg_reg[`TPC_IN_STAT_BIT];
         act_reg.volt_value <= vset_reg;
         act_reg.freq_value <= fset_reg;
         act_reg.preset_slot <= in_cfg_reg[`TPC_IN_SLOT_LSB +: 4];
         // Remote requests are always passed on
         act_reg.remote_trig <= remote_in_reg;
         if (in_fire) begin
            case (in_action)
               tpc_pkg::TPC_ACT_OUTPUT: begin
                  act_reg.out_ctrl_pulse <= 1'b1;
               end
               tpc_pkg::TPC_ACT_SETTING: begin
                  act_reg.setting_pulse <= 1'b1;
               end
               tpc_pkg::TPC_ACT_PRESET: begin
                  act_reg.preset_pulse <= 1'b1;
               end
               tpc_pkg::TPC_ACT_SURGE: begin
                  act_reg.surge_start <= 1'b1;
               end
               default: begin
                  act_reg.out_ctrl_pulse <= 1'b0;
               end
            endcase
         end
      end
   end

   // Output source selection
   always_comb begin
      out_event = 1'b0;
      case (out_source)
         tpc_pkg::TPC_SRC_OUTPUT: begin
            out_event = i_evt.output_on || i_evt.output_off;
         end
         tpc_pkg::TPC_SRC_SETTING: begin
            out_event = i_evt.setting_change;
         end
         tpc_pkg::TPC_SRC_PRESET: begin
            out_event = i_evt.preset_save || i_evt.preset_load;
         end
         tpc_pkg::TPC_SRC_ALL: begin
            out_event = |i_evt;
         end
         default: begin
            out_event = 1'b0;
         end
      endcase
      // Internal events ignored in test modes; remote still works
      out_event = (out_event && !i_test_mode) || remote_out_reg;
   end

   // Pulse timer; a new event during a pulse restarts it
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         out_busy_reg <= 1'b0;
         out_cyc_reg <= 32'h0000_0000;
         out_ms_reg <= 6'h00;
      end else if (out_event && (out_width != 6'h00)) begin
         out_busy_reg <= 1'b1;
         out_cyc_reg <= 32'h0000_0000;
         out_ms_reg <= 6'h00;
      end else if (out_busy_reg) begin
         if (out_cyc_reg == P_MS_CYCLES - 1) begin
            out_cyc_reg <= 32'h0000_0000;
            out_ms_reg <= out_ms_reg + 6'h01;
            if (out_ms_reg + 6'h01 >= out_width) begin
               out_busy_reg <= 1'b0;
            end
         end else begin
            out_cyc_reg <= out_cyc_reg + 32'h0000_0001;
         end
      end
   end

   // Static mode: event latches the pin until the output setup is rewritten
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         out_latch_reg <= 1'b0;
      end else if (out_event && (out_width == 6'h00)) begin
         out_latch_reg <= 1'b1;
      end else if (wr_en && (i_avs_address == `TPC_OFS_OUT_CFG)) begin
         out_latch_reg <= 1'b0;
      end
   end

   // Level applies only at zero width; idle is the opposite level
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         trig_out_reg <= 1'b0;
      end else if (out_width == 6'h00) begin
         trig_out_reg <= out_latch_reg ? out_level : !out_level;
      end else begin
         trig_out_reg <= out_busy_reg;
      end
   end

   assign o_avs_waitrequest = wait_reg;
   assign o_avs_readdata = rdata_reg;
   assign o_trig_out = trig_out_reg;
   assign o_act = act_reg;

endmodule : tpc_trigger_pin_ctrl

`default_nettype wire
